// ===== verilog/dsu_status.sv
// dma status unit: collision flags, last channel, ping-pong state, last ram address
//
// Notes on behaviour
// R1: per channel, set peripheral write collision flag when collision detected
// R2: per channel, set ram write collision flag when collision detected
// R3: last active channel field; 1111 after reset, else channel 0-7
// R4: per-channel ping-pong bit; 1 means secondary start offset selected, resets 0
// R5: capture most recent ram address accessed by any channel, resets zero
// R6: in ping-pong mode alternate primary and secondary buffer each block
// R7: hardware only sets flags; software writes zero to clear; set wins
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dsu_status
   import dsu_pkg::*;
#(
   parameter int NCH = DSU_NCH
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire dsu_xfer_t xfer, // transfer report from engines
   output logic [NCH-1:0] pingpong_buffer_select, // current buffer per channel
   output logic irq // level interrupt
);
   initial begin
      if (NCH != 8) $error("dsu_status supports exactly eight channels");
   end

   dsu_apb_req_t req;
   assign req = '{psel, penable, pwrite, paddr, pwdata};

   logic [NCH-1:0] periph_write_collision_flag_q, periph_write_collision_flag_d;
   logic [NCH-1:0] ram_write_collision_flag_q, ram_write_collision_flag_d;
   logic [3:0] last_active_channel_q, last_active_channel_d;
   logic [15:0] last_ram_address_q, last_ram_address_d;
   logic [NCH-1:0] pp_mode_q, pp_mode_d;
   logic [15:0] irq_stat_q, irq_stat_d;
   logic [15:0] irq_mask_q, irq_mask_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d, irq_d;
   logic [NCH-1:0] pp_sel;
   logic wr_en, rd_en, setup;

   // one-hot decode of a channel number
   function automatic logic [NCH-1:0] chan_hot(input logic [2:0] ch);
      chan_hot = '0;
      chan_hot[ch] = 1'b1;
   endfunction : chan_hot

   // apb access phase qualifiers; slave answers in the first access cycle
   assign setup = req.psel && !req.penable;
   assign wr_en = req.psel && req.penable && req.pwrite && pready;
   assign rd_en = req.psel && req.penable && !req.pwrite && pready;

   logic [NCH-1:0] per_set, ram_set, blk;
   // per-channel events from the transfer report
   always_comb begin
      per_set = '0;
      ram_set = '0;
      blk = '0;
      if (xfer.valid) begin
         per_set = xfer.periph_coll ? chan_hot(xfer.chan) : '0;
         ram_set = xfer.ram_coll ? chan_hot(xfer.chan) : '0;
         blk = xfer.block_done ? chan_hot(xfer.chan) : '0;
      end
   end

   dsu_pingpong #(
      .NCH(NCH)
   ) u_pp (
      .pclk(pclk),
      .presetn(presetn),
      .pp_enable(pp_mode_q),
      .block_done(blk),
      .sel_q(pp_sel)
   );

   // status registers next state
   always_comb begin
      periph_write_collision_flag_d = periph_write_collision_flag_q;
      ram_write_collision_flag_d = ram_write_collision_flag_q;
      last_active_channel_d = last_active_channel_q;
      last_ram_address_d = last_ram_address_q;
      pp_mode_d = pp_mode_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      // software may only clear collision flags by writing zero
      if (wr_en && req.paddr == DSU_OFF_COLL) begin
         periph_write_collision_flag_d = periph_write_collision_flag_q
            & req.pwdata[DSU_POS_PERIPH +: NCH]; // R7
         ram_write_collision_flag_d = ram_write_collision_flag_q
            & req.pwdata[DSU_POS_RAM +: NCH]; // R7
      end
      if (wr_en && req.paddr == DSU_OFF_IRQ_MASK) begin
         irq_mask_d = req.pwdata[15:0];
      end
      if (wr_en && req.paddr == DSU_OFF_PP_MODE) begin
         pp_mode_d = req.pwdata[NCH-1:0];
      end
      if (rd_en && req.paddr == DSU_OFF_IRQ_STAT) begin
         irq_stat_d = '0; // read clears
      end
      // hardware sets after the clear so a same-cycle event wins
      periph_write_collision_flag_d = periph_write_collision_flag_d | per_set; // R1 R7
      ram_write_collision_flag_d = ram_write_collision_flag_d | ram_set; // R2 R7
      irq_stat_d = irq_stat_d | {per_set, ram_set};
      if (xfer.valid) begin
         last_active_channel_d = {1'b0, xfer.chan}; // R3
         last_ram_address_d = xfer.ram_addr; // R5
      end
   end

   // status registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_write_collision_flag_q <= '0; // R1
         ram_write_collision_flag_q <= '0; // R2
         last_active_channel_q <= DSU_LAST_NONE; // R3
         last_ram_address_q <= DSU_ADDR_RST; // R5
         pp_mode_q <= DSU_PP_RST[NCH-1:0];
         irq_stat_q <= '0;
         irq_mask_q <= DSU_IRQ_MASK_RST;
      end else begin
         periph_write_collision_flag_q <= periph_write_collision_flag_d;
         ram_write_collision_flag_q <= ram_write_collision_flag_d;
         last_active_channel_q <= last_active_channel_d;
         last_ram_address_q <= last_ram_address_d;
         pp_mode_q <= pp_mode_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // apb answer and output next state
   always_comb begin
      pready_d = setup; // ready for exactly the first access cycle
      pslverr_d = 1'b0;
      prdata_d = '0;
      if (setup) begin
         unique case (req.paddr)
            DSU_OFF_COLL: begin
               prdata_d[DSU_POS_PERIPH +: NCH] = periph_write_collision_flag_q; // R1
               prdata_d[DSU_POS_RAM +: NCH] = ram_write_collision_flag_q; // R2
            end
            DSU_OFF_CHAN: begin
               prdata_d[DSU_POS_LAST +: 4] = last_active_channel_q; // R3
               prdata_d[DSU_POS_PP +: NCH] = pp_sel; // R4
            end
            DSU_OFF_ADDR: prdata_d[15:0] = last_ram_address_q; // R5
            DSU_OFF_IRQ_STAT: prdata_d[15:0] = irq_stat_q;
            DSU_OFF_IRQ_MASK: prdata_d[15:0] = irq_mask_q;
            DSU_OFF_PP_MODE: prdata_d[NCH-1:0] = pp_mode_q;
            default: pslverr_d = 1'b1;
         endcase
      end
      irq_d = |(irq_stat_d & irq_mask_d);
   end

   // apb and output registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         pingpong_buffer_select <= '0;
      end else begin
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         irq <= irq_d;
         pingpong_buffer_select <= pp_sel; // R4
      end
   end

   per_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (xfer.valid && xfer.periph_coll) |=> periph_write_collision_flag_q[$past(xfer.chan)]) // R1
      else $error("peripheral collision flag not set");
   ram_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (xfer.valid && xfer.ram_coll) |=> ram_write_collision_flag_q[$past(xfer.chan)]) // R2
      else $error("ram collision flag not set");
   last_chan_a: assert property (@(posedge pclk) disable iff (!presetn)
      xfer.valid |=> last_active_channel_q == {1'b0, $past(xfer.chan)}) // R3
      else $error("last channel not recorded");
   last_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      last_active_channel_q == DSU_LAST_NONE || !last_active_channel_q[3]) // R3
      else $error("last channel holds reserved code");
   pp_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 pingpong_buffer_select == $past(pp_sel)) // R4
      else $error("ping-pong output lags");
   last_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      xfer.valid |=> last_ram_address_q == $past(xfer.ram_addr)) // R5
      else $error("ram address not captured");
   flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      (periph_write_collision_flag_q[0] && !(wr_en && req.paddr == DSU_OFF_COLL))
      |=> periph_write_collision_flag_q[0]) // R7
      else $error("collision flag cleared by hardware");
   set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && req.paddr == DSU_OFF_COLL && xfer.valid && xfer.ram_coll)
      |=> ram_write_collision_flag_q[$past(xfer.chan)]) // R7
      else $error("clear beat a same-cycle set");
   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready)
      else $error("apb answer late");

   // apb answer stands for one cycle only
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("apb ready held too long");
   // error flag only together with the answer
   slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("apb error outside answer");
   // read data bus is quiet between answers
   rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data not quiet");

   // interrupt line follows the masked status
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(irq_stat_q & irq_mask_q))
      else $error("interrupt level wrong");
   // status read clears when no event competes
   stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && req.paddr == DSU_OFF_IRQ_STAT && !xfer.valid)
      |=> irq_stat_q == 16'h0000)
      else $error("status read did not clear");
   // mask register takes the written word
   mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && req.paddr == DSU_OFF_IRQ_MASK)
      |=> irq_mask_q == $past(req.pwdata[15:0]))
      else $error("mask write lost");
   // mode register takes the written word
   mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && req.paddr == DSU_OFF_PP_MODE)
      |=> pp_mode_q == $past(req.pwdata[NCH-1:0]))
      else $error("mode write lost");

   // last channel and address hold without a transfer
   last_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !xfer.valid |=> $stable(last_active_channel_q)) // R3
      else $error("last channel changed without transfer");
   addr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !xfer.valid |=> $stable(last_ram_address_q)) // R5
      else $error("ram address changed without transfer");
   // write-zero clears exactly the zero peripheral flag bits when nothing competes
   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && req.paddr == DSU_OFF_COLL && !xfer.valid)
      |=> periph_write_collision_flag_q
      == $past(periph_write_collision_flag_q & req.pwdata[DSU_POS_PERIPH +: NCH])) // R7
      else $error("write-zero clear wrong");
   // ram flag of channel 0 never drops without a clear write
   ram_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ram_write_collision_flag_q[0] && !(wr_en && req.paddr == DSU_OFF_COLL))
      |=> ram_write_collision_flag_q[0]) // R7
      else $error("ram flag cleared by hardware");
endmodule : dsu_status
`default_nettype wire

// ===== verilog/dsu_pkg.sv
// package: register map, field layout and carrier types of the dma status unit
package dsu_pkg;
   localparam int DSU_NCH = 8;
   localparam logic [11:0] DSU_OFF_COLL = 12'h000;
   localparam logic [11:0] DSU_OFF_CHAN = 12'h004;
   localparam logic [11:0] DSU_OFF_ADDR = 12'h008;
   localparam logic [11:0] DSU_OFF_IRQ_STAT = 12'h00C;
   localparam logic [11:0] DSU_OFF_IRQ_MASK = 12'h010;
   localparam logic [11:0] DSU_OFF_PP_MODE = 12'h014;
   localparam int DSU_POS_PERIPH = 8;
   localparam int DSU_POS_RAM = 0;
   localparam int DSU_POS_LAST = 8;
   localparam int DSU_POS_PP = 0;
   localparam logic [3:0] DSU_LAST_NONE = 4'hF;
   localparam logic [15:0] DSU_ADDR_RST = 16'h0000;
   localparam logic [7:0] DSU_PP_RST = 8'h00;
   localparam logic [15:0] DSU_IRQ_MASK_RST = 16'h0000;
   // transfer report from a channel engine
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic [15:0] ram_addr;
      logic block_done;
      logic periph_coll;
      logic ram_coll;
   } dsu_xfer_t;
   // apb request as seen by the slave
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } dsu_apb_req_t;
endpackage : dsu_pkg

// ===== verilog/dsu_pingpong.sv
// ping-pong buffer selector for all channels
`timescale 1ns/1ps
`default_nettype none
module dsu_pingpong
   import dsu_pkg::*;
#(
   parameter int NCH = DSU_NCH
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [NCH-1:0] pp_enable, // ping-pong mode per channel
   input wire logic [NCH-1:0] block_done, // block finished pulse per channel
   output logic [NCH-1:0] sel_q // 1 = secondary start offset selected
);
   logic [NCH-1:0] sel_d;
   // toggle the selection at each finished block in ping-pong mode
   always_comb begin
      sel_d = sel_q & pp_enable; // R6
      sel_d = sel_d ^ (block_done & pp_enable); // R6
   end
   // selector register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= DSU_PP_RST[NCH-1:0]; // R4
      end else begin
         sel_q <= sel_d;
      end
   end
   // every channel with a finished block in ping-pong mode flips its selection
   pp_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|(block_done & pp_enable)) |=>
      (((sel_q ^ $past(sel_q)) & $past(block_done & pp_enable))
      == $past(block_done & pp_enable))) // R6
      else $error("ping-pong select did not toggle");
endmodule : dsu_pingpong
`default_nettype wire

// ===== sim/dsu_engine_model.sv
// channel engine model: issues one-cycle transfer reports to the status unit
`timescale 1ns/1ps
`default_nettype none
module dsu_engine_model
   import dsu_pkg::*;
(
   input wire logic pclk, // system clock
   output dsu_xfer_t xfer // transfer report
);
   initial xfer = '0;
   // one report per call; fields scrambled once valid drops so stale data never matches
   task automatic send(input logic [2:0] c, input logic [15:0] a, input logic bd, pc, rc);
      @(posedge pclk);
      xfer <= '{1'b1, c, a, bd, pc, rc};
      @(posedge pclk);
      xfer <= '{1'b0, ~c, ~a, ~bd, ~pc, ~rc};
   endtask : send
endmodule : dsu_engine_model
`default_nettype wire

// ===== sim/tb_dsu_status.sv
// testbench: status unit driven over apb and by the engine model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_dsu_status;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, exp;
   logic [7:0] pingpong_buffer_select;
   dsu_pkg::dsu_xfer_t xfer;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   dsu_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .xfer(xfer), .pingpong_buffer_select(pingpong_buffer_select),
      .irq(irq));
   dsu_engine_model u_eng (.pclk(pclk), .xfer(xfer));
   // clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic r;
      apb(1'b0, a, 32'h0, d, r);
      `CHK("prdata", e, d)
      `CHK("pslverr", 1'b0, r)
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic r;
      apb(1'b1, a, v, d, r);
   endtask : wr
   // reset values, unmapped access
   task automatic t_reset;
      logic [31:0] d;
      logic r;
      `CHK("ppsel", 8'h00, pingpong_buffer_select)
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0000_0F00);
      rd(12'h008, 32'h0);
      apb(1'b0, 12'h020, 32'h0, d, r);
      `CHK("slverr", 1'b1, r)
      `CHK("err_data", 32'h0, d)
   endtask : t_reset
   // every channel reports, flags pile up; write-zero clears, read-only stays
   task automatic t_coll;
      exp = 32'h0;
      for (int c = 0; c < 8; c++) begin
         u_eng.send(3'(c), 16'h1230 + 16'(c), 1'b0, c[0], ~c[0]);
         exp = exp | (c[0] ? (32'h100 << c) : (32'h1 << c));
         rd(12'h000, exp);
         rd(12'h004, 32'(c) << 8);
         rd(12'h008, 32'h1230 + 32'(c));
      end
      wr(12'h004, 32'hFFFF);
      wr(12'h008, 32'hFFFF);
      rd(12'h004, 32'h0700);
      rd(12'h008, 32'h1237);
      wr(12'h000, 32'hFF00);
      rd(12'h000, exp & 32'hFF00);
      wr(12'h000, 32'h0);
      rd(12'h000, 32'h0);
      rd(12'h00C, exp);
      rd(12'h00C, 32'h0);
      // clear write and ram collision of channel 2 in one cycle: the set wins
      fork
         wr(12'h000, 32'h0);
         begin
            @(posedge pclk);
            u_eng.send(3'd2, 16'h0010, 1'b0, 1'b0, 1'b1);
         end
      join
      rd(12'h000, 32'h4);
      wr(12'h000, 32'h0);
      rd(12'h000, 32'h0);
      rd(12'h00C, 32'h4);
   endtask : t_coll
   // ping-pong alternation only where mode is on
   task automatic t_pp;
      wr(12'h014, 32'h08);
      rd(12'h014, 32'h08);
      u_eng.send(3'd3, 16'h0040, 1'b1, 1'b0, 1'b0);
      rd(12'h004, 32'h0308);
      `CHK("ppsel", 8'h08, pingpong_buffer_select)
      u_eng.send(3'd3, 16'h0080, 1'b1, 1'b0, 1'b0);
      u_eng.send(3'd5, 16'h00C0, 1'b1, 1'b0, 1'b0);
      rd(12'h004, 32'h0500);
      `CHK("ppsel", 8'h00, pingpong_buffer_select)
   endtask : t_pp
   // masked event keeps irq low, unmasked raises it, status read drops it
   task automatic t_irq;
      wr(12'h010, 32'h1);
      rd(12'h010, 32'h1);
      u_eng.send(3'd1, 16'h0002, 1'b0, 1'b0, 1'b1);
      repeat (3) @(posedge pclk);
      `CHK("irq", 1'b0, irq)
      u_eng.send(3'd0, 16'h0004, 1'b0, 1'b0, 1'b1);
      repeat (3) @(posedge pclk);
      `CHK("irq", 1'b1, irq)
      rd(12'h00C, 32'h3);
      repeat (3) @(posedge pclk);
      `CHK("irq", 1'b0, irq)
   endtask : t_irq
   // main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_coll();
      t_pp();
      t_irq();
      end_sim();
   end
endmodule : tb_dsu_status
`default_nettype wire
